//--- ebw_pkg.sv
// shared constants and types for the two-wire memory control block
`default_nettype none
package ebw_pkg;
   // type nibble of the slave address: the value is arbitrary
   localparam logic [3:0] DEV_TYPE = 4'h6;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam int PAGE_BYTES = 8;
   localparam int ADDR_BITS = 8;
   localparam int CLK_MHZ = 50;
   localparam int PROG_TIME_US = 5000;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DEVADDR = 7'h02,
      ST_WORDADDR = 7'h04,
      ST_WDATA = 7'h08,
      ST_RDATA = 7'h10,
      ST_WAITSTOP = 7'h20,
      ST_SPARE = 7'h40
   } ebw_state_t;
endpackage
`default_nettype wire

//--- ebw_cond_if.sv
// bus condition events passed from the line sampler to the command engine
`timescale 1ns/100ps
`default_nettype none
interface ebw_cond_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda;
   modport det (output scl_rise, output scl_fall, output start, output stop, output sda);
   modport ctl (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface
`default_nettype wire

//--- ebw_cond.sv
// line sampler: clock edges, start and stop conditions
`timescale 1ns/100ps
`default_nettype none
module ebw_cond (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   ebw_cond_if.det cnd
);
   typedef struct packed {
      logic scl;
      logic sda;
   } ebw_line_t;

   ebw_line_t q;
   ebw_line_t d;

   always_comb
   begin
      d.scl = scl_i;
      d.sda = sda_i;
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         q <= '{scl: 1'b1, sda: 1'b1};
      end
      else
      begin
         q <= d;
      end
   end

   // sda moving while scl is high is a condition, never data
   assign cnd.scl_rise = scl_i & ~q.scl;
   assign cnd.scl_fall = ~scl_i & q.scl;
   assign cnd.start = scl_i & q.scl & q.sda & ~sda_i;
   assign cnd.stop = scl_i & q.scl & ~q.sda & sda_i;
   assign cnd.sda = sda_i;
endmodule
`default_nettype wire

//--- ebw_top.sv
// two-wire byte memory: command engine, write guard and self-timed program cycle
//
// Summary of operation
// - memory may keep pulling data low during dummy clocks for ack or read.
// - every command opens with a start; after recovery a fresh start is needed.
// - during the program cycle every command, own address included, gets no ack.
// - start followed by stop abandons a partial command and returns to standby.
// - after cancelling a read, address counter is undefined; use random read.
// - writes are inhibited while the low-supply indication is asserted.
// - write-protect high refuses all writes unless it rises only in the last clock of the program cycle; low allows reads and writes.
// - memory answers only when the three select bits equal its select pins.
// - slave address is type nibble, three select bits, then direction (1 = read).
// - a read byte left unacknowledged stops sending; memory waits for stop.
// - the program cycle starts only on a stop after write data.
`timescale 1ns/100ps
`default_nettype none
module ebw_top #(
   parameter int PROG_CYCLES = ebw_pkg::PROG_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic chip_select_bit0_i,
   input wire logic chip_select_bit1_i,
   input wire logic chip_select_bit2_i,
   input wire logic write_protect_i,
   input wire logic low_supply_write_lock_i,
   output logic program_busy_o
);
   localparam int PW = $clog2(PROG_CYCLES + 1);
   localparam int AW = ebw_pkg::ADDR_BITS;
   localparam int PB = ebw_pkg::PAGE_BYTES;

   typedef struct packed {
      ebw_pkg::ebw_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [AW-1:0] addr;
      logic [PB-1:0][7:0] pg;
      logic [PB-1:0] pmask;
      logic [PW-1:0] prog;
      logic abort;
      logic oe;
      logic busy;
      logic lvl;
      logic lead;
   } ebw_core_t;

   localparam ebw_core_t RST_STATE = '{st: ebw_pkg::ST_IDLE, default: '0};

   ebw_core_t q;
   ebw_core_t d;
   logic [7:0] mem [0:(1<<AW)-1];
   logic commit;
   logic [2:0] cs_pins;

   ebw_cond_if cnd ();

   ebw_cond i_ebw_cond (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .cnd(cnd)
   );

   assign cs_pins = {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i};
   // a supply dip in the last cycle still blocks the array update
   assign commit = (q.prog == PW'(1)) && !q.abort && !low_supply_write_lock_i;

   always_comb
   begin
      d = q;
      d.lvl = 1'b0;
      if (q.prog != '0)
      begin
         d.prog = q.prog - PW'(1);
         // protect before the last cycle or low supply in any cycle cancels its array update; the count still runs out
         if (write_protect_i || low_supply_write_lock_i)
         begin
            d.abort = 1'b1;
         end
      end
      if (cnd.start)
      begin
         // start wins over everything, whatever the interrupted state
         d.oe = 1'b0;
         d.cnt = '0;
         d.lead = 1'b1;
         d.st = (q.prog != '0) ? ebw_pkg::ST_IDLE : ebw_pkg::ST_DEVADDR;
      end
      else if (cnd.stop)
      begin
         d.oe = 1'b0;
         // a cancelled read leaves the address pointer wherever it stood
         d.st = ebw_pkg::ST_IDLE;
         if (q.st == ebw_pkg::ST_WDATA && q.pmask != '0 && q.prog == '0 &&
             !write_protect_i && !low_supply_write_lock_i)
         begin
            d.prog = PW'(PROG_CYCLES);
            d.abort = 1'b0;
         end
      end
      else
      begin
         case (q.st)
            ebw_pkg::ST_IDLE, ebw_pkg::ST_WAITSTOP:
            begin
               d.oe = 1'b0;
            end
            ebw_pkg::ST_DEVADDR, ebw_pkg::ST_WORDADDR, ebw_pkg::ST_WDATA, ebw_pkg::ST_RDATA:
            begin
               if (cnd.scl_rise && q.cnt < ebw_pkg::ACK_SLOT && q.st != ebw_pkg::ST_RDATA)
               begin
                  d.sh = {q.sh[6:0], cnd.sda};
               end
               if (cnd.scl_rise && q.st == ebw_pkg::ST_RDATA && q.cnt == ebw_pkg::ACK_SLOT && cnd.sda)
               begin
                  d.st = ebw_pkg::ST_WAITSTOP;
               end
               // the clock fall that closes a start is no data bit
               if (cnd.scl_fall && q.lead)
               begin
                  d.lead = 1'b0;
               end
               else if (cnd.scl_fall)
               begin
                  if (q.cnt == ebw_pkg::BYTE_LAST)
                  begin
                     d.cnt = ebw_pkg::ACK_SLOT;
                     case (q.st)
                        ebw_pkg::ST_DEVADDR:
                        begin
                           if (q.sh[7:4] == ebw_pkg::DEV_TYPE && q.sh[3:1] == cs_pins)
                           begin
                              d.oe = 1'b1;
                           end
                           else
                           begin
                              d.st = ebw_pkg::ST_IDLE;
                           end
                        end
                        ebw_pkg::ST_WORDADDR:
                        begin
                           d.oe = 1'b1;
                           d.addr = q.sh;
                           d.pmask = '0;
                        end
                        ebw_pkg::ST_WDATA:
                        begin
                           // page rolls over in its low three bits
                           d.oe = 1'b1;
                           d.pg[q.addr[2:0]] = q.sh;
                           d.pmask[q.addr[2:0]] = 1'b1;
                           d.addr = {q.addr[AW-1:3], q.addr[2:0] + 3'h1};
                        end
                        default:
                        begin
                           d.oe = 1'b0;
                           d.addr = q.addr + AW'(1);
                        end
                     endcase
                  end
                  else if (q.cnt == ebw_pkg::ACK_SLOT)
                  begin
                     d.cnt = '0;
                     d.oe = 1'b0;
                     if (q.st == ebw_pkg::ST_DEVADDR && !q.sh[0])
                     begin
                        d.st = ebw_pkg::ST_WORDADDR;
                     end
                     else if (q.st == ebw_pkg::ST_WORDADDR)
                     begin
                        d.st = ebw_pkg::ST_WDATA;
                     end
                     else if (q.st == ebw_pkg::ST_DEVADDR || q.st == ebw_pkg::ST_RDATA)
                     begin
                        d.st = ebw_pkg::ST_RDATA;
                        d.sh = mem[q.addr];
                        d.oe = ~mem[q.addr][7];
                     end
                  end
                  else
                  begin
                     d.cnt = q.cnt + 4'h1;
                     if (q.st == ebw_pkg::ST_RDATA)
                     begin
                        // keeps pulling low through dummy clocks if the bit is zero
                        d.sh = {q.sh[6:0], 1'b0};
                        d.oe = ~q.sh[6];
                     end
                  end
               end
            end
            default:
            begin
               d.st = ebw_pkg::ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end
      d.busy = (d.prog != '0);
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         q <= RST_STATE;
      end
      else
      begin
         q <= d;
      end
   end

   // array has no reset: contents survive a reset like the real cells
   always_ff @(posedge ref_clk_i)
   begin
      if (commit)
      begin
         for (int i = 0; i < PB; i++)
         begin
            if (q.pmask[i])
            begin
               mem[{q.addr[AW-1:3], 3'(i)}] <= q.pg[i];
            end
         end
      end
   end

   assign sda_o = q.lvl;
   assign sda_oe_o = q.oe;
   assign program_busy_o = q.busy;

   a_busy_start_ignored: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (cnd.start && q.busy) |=> ((q.st == ebw_pkg::ST_IDLE) && !q.oe) [*2])
      else $error("command taken during program cycle");

   a_start_clears_count: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (cnd.start && !q.busy) |=> (q.st == ebw_pkg::ST_DEVADDR) && (q.cnt == 4'h0) && !q.oe)
      else $error("start did not restart the address phase");

   a_stop_standby: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (cnd.stop && !cnd.start) |=> (q.st == ebw_pkg::ST_IDLE) && !q.oe)
      else $error("stop did not return to standby");

   a_prog_needs_stop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(q.busy) |-> $past(cnd.stop) && ($past(q.st) == ebw_pkg::ST_WDATA))
      else $error("program cycle began without stop after data");

   a_protect_blocks: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(q.busy) |-> !$past(write_protect_i))
      else $error("program cycle began under write protect");

   a_lock_no_commit: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      commit |-> !low_supply_write_lock_i && !$past(low_supply_write_lock_i))
      else $error("array written under low supply");

   a_addr_match_ack: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ($rose(q.oe) && q.st == ebw_pkg::ST_DEVADDR) |-> (q.sh[3:1] == cs_pins) && (q.sh[7:4] == ebw_pkg::DEV_TYPE))
      else $error("address acknowledged without select match");

   a_nack_waits: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (cnd.scl_rise && cnd.sda && !cnd.start && !cnd.stop && q.st == ebw_pkg::ST_RDATA &&
       q.cnt == ebw_pkg::ACK_SLOT) |=> (q.st == ebw_pkg::ST_WAITSTOP) ##1 !q.oe)
      else $error("read continued after missing acknowledge");

   a_busy_ends: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      (q.prog == PW'(1)) |=> !q.busy)
      else $error("program cycle did not end on count");
endmodule
`default_nettype wire

//--- ebw_master.sv
// two-wire bus master model: drives clock and open-drain data
`timescale 1ns/100ps
`default_nettype none
module ebw_master (
   input wire logic ref_clk_i,
   input wire logic sda_i,
   output var logic scl_o,
   output var logic sda_oe_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // four clocks a half bit keeps each clock level above the two-clock minimum
   task automatic half();
      repeat (4) @(negedge ref_clk_i);
   endtask
   // a one is sent by releasing data, never by driving it high
   task automatic clk_bit(input logic b, output logic s);
      sda_oe_o = ~b;
      half();
      scl_o = 1'b1;
      half();
      s = sda_i;
      scl_o = 1'b0;
      half();
   endtask
   task automatic start_cond();
      sda_oe_o = 1'b0;
      half();
      scl_o = 1'b1;
      half();
      sda_oe_o = 1'b1;
      half();
      scl_o = 1'b0;
      half();
   endtask
   task automatic stop_cond();
      sda_oe_o = 1'b1;
      half();
      scl_o = 1'b1;
      half();
      sda_oe_o = 1'b0;
      half();
   endtask
   task automatic dummy(input int n);
      logic s;
      repeat (n) clk_bit(1'b1, s);
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
   endtask
   task automatic get_byte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(~mack, s);
   endtask
endmodule
`default_nettype wire

//--- ebw_bench.sv
// self-checking bench: addressing, program cycle, write guard, cancel, recovery
`timescale 1ns/100ps
`default_nettype none
module ebw_bench;
   localparam int PROG = 400;
   localparam logic [7:0] AW = {ebw_pkg::DEV_TYPE, 3'h5, 1'b0};
   localparam logic [7:0] AR = {ebw_pkg::DEV_TYPE, 3'h5, 1'b1};
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, m_oe, dut_oe, dut_sda, busy, ack, s;
   logic wp = 1'b0;
   logic lock = 1'b0;
   logic [2:0] cs = 3'h5;
   logic [7:0] rd;
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;
   // pull-up: the line is low while either end pulls
   wire logic sda = ~(m_oe | dut_oe);
   ebw_master i_ebw_master (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
   ebw_top #(.PROG_CYCLES(PROG)) i_ebw_top (.ref_clk_i(ref_clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda),
      .sda_o(dut_sda), .sda_oe_o(dut_oe), .chip_select_bit0_i(cs[0]), .chip_select_bit1_i(cs[1]),
      .chip_select_bit2_i(cs[2]), .write_protect_i(wp), .low_supply_write_lock_i(lock), .program_busy_o(busy));
   initial forever #10 ref_clk = ~ref_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic write_byte(input logic [7:0] wa, input logic [7:0] d);
      i_ebw_master.start_cond();
      i_ebw_master.put_byte(AW, ack);
      i_ebw_master.put_byte(wa, ack);
      i_ebw_master.put_byte(d, ack);
      i_ebw_master.stop_cond();
   endtask
   // random read, the only safe read after a cancelled command
   task automatic read_at(input logic [7:0] wa, output logic [7:0] d);
      i_ebw_master.start_cond();
      i_ebw_master.put_byte(AW, ack);
      i_ebw_master.put_byte(wa, ack);
      i_ebw_master.start_cond();
      i_ebw_master.put_byte(AR, ack);
      chk(ack, 1'b1, "read address not acked");
      i_ebw_master.get_byte(1'b0, d);
      chk(dut_oe, 1'b0, "data still driven after nack");
      i_ebw_master.clk_bit(1'b1, s);
      chk(s, 1'b1, "data pulled low after nack");
      i_ebw_master.stop_cond();
   endtask
   task automatic t_select();
      for (int a = 0; a < 8; a++)
      begin
         cs = 3'(a);
         i_ebw_master.start_cond();
         i_ebw_master.put_byte({ebw_pkg::DEV_TYPE, 3'(a), 1'b0}, ack);
         chk(ack, 1'b1, "own address not acked");
         i_ebw_master.start_cond();
         i_ebw_master.put_byte({ebw_pkg::DEV_TYPE, 3'(a ^ 1), 1'b1}, ack);
         chk(ack, 1'b0, "foreign address acked");
         i_ebw_master.start_cond();
         i_ebw_master.put_byte({4'h5, 3'(a), 1'b0}, ack);
         chk(ack, 1'b0, "wrong type acked");
         i_ebw_master.stop_cond();
      end
      cs = 3'h5;
   endtask
   task automatic t_program();
      write_byte(8'h12, 8'h5a);
      chk(busy, 1'b1, "no program cycle after stop");
      i_ebw_master.start_cond();
      i_ebw_master.put_byte(AW, ack);
      chk(ack, 1'b0, "acked while programming");
      i_ebw_master.stop_cond();
      for (int n = 0; n < 2 * PROG && busy; n++) @(negedge ref_clk);
      chk(busy, 1'b0, "program cycle too long");
      read_at(8'h12, rd);
      chk(rd, 8'h5a, "written byte lost");
   endtask
   // wp high must still allow the read that follows
   task automatic t_guard();
      for (int k = 0; k < 2; k++)
      begin
         wp = (k == 0);
         lock = (k == 1);
         write_byte(8'h12, 8'ha5);
         chk(busy, 1'b0, "guarded write started");
         read_at(8'h12, rd);
         chk(rd, 8'h5a, "guarded location changed");
      end
      wp = 1'b0;
      lock = 1'b0;
   endtask
   task automatic t_cancel();
      i_ebw_master.start_cond();
      i_ebw_master.put_byte(AW, ack);
      i_ebw_master.put_byte(8'h12, ack);
      i_ebw_master.put_byte(8'hc3, ack);
      i_ebw_master.start_cond();
      i_ebw_master.stop_cond();
      chk(busy, 1'b0, "cancelled write programmed");
      read_at(8'h12, rd);
      chk(rd, 8'h5a, "cancelled write changed data");
   endtask
   task automatic t_recover();
      i_ebw_master.start_cond();
      i_ebw_master.put_byte(AW, ack);
      i_ebw_master.put_byte(8'h12, ack);
      i_ebw_master.start_cond();
      i_ebw_master.put_byte(AR, ack);
      i_ebw_master.clk_bit(1'b1, s);
      chk(s, 1'b0, "read bit not driven during dummy clocks");
      chk(dut_sda, 1'b0, "data drive level not low");
      i_ebw_master.dummy(13);
      i_ebw_master.start_cond();
      i_ebw_master.start_cond();
      i_ebw_master.put_byte(AW, ack);
      chk(ack, 1'b1, "no ack after first recovery");
      i_ebw_master.clk_bit(1'b0, s);
      i_ebw_master.start_cond();
      i_ebw_master.dummy(9);
      i_ebw_master.start_cond();
      i_ebw_master.put_byte(AW, ack);
      chk(ack, 1'b1, "no ack after second recovery");
      i_ebw_master.stop_cond();
   endtask
   task automatic t_reset();
      write_byte(8'h20, 8'h11);
      chk(busy, 1'b1, "no program cycle before reset");
      nrst = 1'b0;
      @(negedge ref_clk);
      chk(busy, 1'b0, "program cycle survives reset");
      chk(dut_oe, 1'b0, "data driven in reset");
      nrst = 1'b1;
   endtask
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         fail_count++;
         complete_run();
      end
   end
   initial
   begin
      repeat (8) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      chk(busy, 1'b0, "busy after reset");
      t_select();
      t_program();
      t_guard();
      t_cancel();
      t_recover();
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire
